// ==== include/cdib_pkg.sv ====
package cdib_pkg;

  // ---------------------------------------------------------------
  // opcode encodings and decode masks
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_DIVIDE        = 8'h84;
  localparam logic [7:0] OPC_DEC_BR_REG    = 8'hD8; // low three bits pick the register
  localparam logic [7:0] OPC_DEC_BR_DIRECT = 8'hD5;
  localparam logic [7:0] OPC_INC_ACC       = 8'h04;
  localparam logic [7:0] OPC_INC_REG       = 8'h08; // low three bits pick the register
  localparam logic [7:0] OPC_INC_INDIRECT  = 8'h06; // lowest bit picks the pointer
  localparam logic [7:0] OPC_INC_DIRECT    = 8'h05;
  localparam logic [7:0] OPC_INC_DATA_PTR  = 8'hA3;
  localparam logic [7:0] OPC_BR_BIT_SET    = 8'h20;
  localparam logic [7:0] OPC_BR_BIT_CLR    = 8'h10;
  localparam logic [7:0] OPC_BR_BIT_NOT    = 8'h30;
  localparam logic [7:0] OPC_BR_CARRY      = 8'h40;
  localparam logic [7:0] OPC_JUMP_INDIRECT = 8'h73;
  localparam logic [7:0] MASK_REG_FORM     = 8'hF8;
  localparam logic [7:0] MASK_PTR_FORM     = 8'hFE;
  localparam logic [7:0] MASK_FULL         = 8'hFF;

  // ---------------------------------------------------------------
  // byte lengths and machine cycle counts
  // ---------------------------------------------------------------
  localparam logic [15:0] LEN_ONE    = 16'h0001;
  localparam logic [15:0] LEN_TWO    = 16'h0002;
  localparam logic [15:0] LEN_THREE  = 16'h0003;
  localparam logic [2:0]  CYC_ONE    = 3'h1;
  localparam logic [2:0]  CYC_TWO    = 3'h2;
  localparam logic [2:0]  CYC_FOUR   = 3'h4;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [15:0] WORD_ONE   = 16'h0001;
  localparam logic [2:0]  CNT_ZERO   = 3'h0;
  localparam logic [2:0]  CNT_ONE    = 3'h1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    CDIB_IDLE = 1'b0,
    CDIB_EXEC = 1'b1
  } cdib_fsm_type;

  // instruction bytes as fetched
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] arg1;   // direct or bit address, or offset of two-byte forms
    logic [7:0] arg2;   // offset of three-byte forms
  } cdib_instr_type;

  // architectural state seen at issue
  typedef struct packed {
    logic [15:0] program_counter;   // address of the opcode byte
    logic [15:0] data_pointer;
    logic [7:0]  acc;
    logic [7:0]  second_operand;
    logic        carry;
  } cdib_arch_type;

  // fetched byte and bit operands, both pin and latch views
  typedef struct packed {
    logic [7:0] byte_pin;
    logic [7:0] byte_latch;
    logic       byte_is_port;
    logic       bit_pin;
    logic       bit_latch;
    logic       bit_is_port;
  } cdib_operand_type;

  // write-back produced by one instruction
  typedef struct packed {
    logic [15:0] program_counter;
    logic [7:0]  acc;
    logic        acc_we;
    logic [7:0]  second_operand;
    logic        second_we;
    logic [15:0] data_pointer;
    logic        data_pointer_we;
    logic        carry;
    logic        carry_we;
    logic        overflow_flag;
    logic        overflow_we;
    logic [7:0]  operand;
    logic        operand_we;
    logic        bit_clear;
    logic        illegal;
  } cdib_result_type;

endpackage : cdib_pkg

// ==== rtl/cdib_exec.sv ====
`timescale 1ns/10ps
module cdib_exec (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      issue,
  input  wire cdib_pkg::cdib_instr_type   instr,
  input  wire cdib_pkg::cdib_arch_type    arch,
  input  wire cdib_pkg::cdib_operand_type opnd,
  output logic                           busy,
  output logic                           done,
  output cdib_pkg::cdib_result_type      result
);
  import cdib_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // opcode match under a mask, used for every decode line
  function automatic logic op_is(input logic [7:0] op, input logic [7:0] pat,
                                 input logic [7:0] mask);
    op_is = ((op & mask) == pat);
  endfunction : op_is

  // branch target: sign-extended offset on the advanced counter
  function automatic logic [15:0] rel_target(input logic [15:0] next_addr,
                                             input logic [7:0]  offset);
    logic [15:0] ext;
    ext        = {{8{offset[7]}}, offset};
    rel_target = 16'(next_addr + ext);
  endfunction : rel_target

  // a port target reads back from its output latch, not the pins
  function automatic logic [7:0] rmw_byte(input cdib_operand_type o);
    rmw_byte = o.byte_is_port ? o.byte_latch : o.byte_pin;
  endfunction : rmw_byte

  function automatic logic rmw_bit(input cdib_operand_type o);
    rmw_bit = o.bit_is_port ? o.bit_latch : o.bit_pin;
  endfunction : rmw_bit

  // one flag per instruction class of this unit's subset
  typedef struct packed {
    logic divide;
    logic dec_br_reg;
    logic dec_br_direct;
    logic inc_acc;
    logic inc_short;       // register or indirect target
    logic inc_direct;
    logic inc_data_ptr;
    logic br_bit_set;
    logic br_bit_clr;
    logic br_bit_not;
    logic br_carry;
    logic jump_indirect;
  } cdib_decode_type;

  // all flags clear means the opcode belongs to another unit
  function automatic cdib_decode_type decode(input logic [7:0] op);
    cdib_decode_type d;
    d               = '0;
    d.divide        = op_is(op, OPC_DIVIDE, MASK_FULL);
    d.dec_br_reg    = op_is(op, OPC_DEC_BR_REG, MASK_REG_FORM);
    d.dec_br_direct = op_is(op, OPC_DEC_BR_DIRECT, MASK_FULL);
    d.inc_acc       = op_is(op, OPC_INC_ACC, MASK_FULL);
    d.inc_short     = op_is(op, OPC_INC_REG, MASK_REG_FORM) ||
                      op_is(op, OPC_INC_INDIRECT, MASK_PTR_FORM);
    d.inc_direct    = op_is(op, OPC_INC_DIRECT, MASK_FULL);
    d.inc_data_ptr  = op_is(op, OPC_INC_DATA_PTR, MASK_FULL);
    d.br_bit_set    = op_is(op, OPC_BR_BIT_SET, MASK_FULL);
    d.br_bit_clr    = op_is(op, OPC_BR_BIT_CLR, MASK_FULL);
    d.br_bit_not    = op_is(op, OPC_BR_BIT_NOT, MASK_FULL);
    d.br_carry      = op_is(op, OPC_BR_CARRY, MASK_FULL);
    d.jump_indirect = op_is(op, OPC_JUMP_INDIRECT, MASK_FULL);
    decode = d;
  endfunction : decode

  // byte length; the counter always steps past it before any offset
  function automatic logic [15:0] instr_len(input cdib_decode_type d);
    if (d.dec_br_direct || d.br_bit_set || d.br_bit_clr || d.br_bit_not) begin
      instr_len = LEN_THREE;
    end else if (d.dec_br_reg || d.inc_direct || d.br_carry) begin
      instr_len = LEN_TWO;
    end else begin
      instr_len = LEN_ONE;
    end
  endfunction : instr_len

  // machine cycles; unknown opcodes take one so the core never stalls
  function automatic logic [2:0] instr_cycles(input cdib_decode_type d);
    if (d.divide) begin
      instr_cycles = CYC_FOUR;
    end else if (d.dec_br_reg || d.dec_br_direct || d.inc_data_ptr || d.br_bit_set ||
                 d.br_bit_clr || d.br_bit_not || d.br_carry || d.jump_indirect) begin
      instr_cycles = CYC_TWO;
    end else begin
      instr_cycles = CYC_ONE;
    end
  endfunction : instr_cycles

  // ---------------------------------------------------------------
  // module state
  // ---------------------------------------------------------------
  typedef struct packed {
    cdib_fsm_type    fsm;
    logic [2:0]      cnt;    // cycles still to run after this one
    cdib_result_type res;
  } cdib_state_type;

  cdib_state_type state_r;
  cdib_state_type state_nxt;

  // ---------------------------------------------------------------
  // decode of the issued opcode
  // ---------------------------------------------------------------
  cdib_decode_type dcd;
  logic [15:0]     exec_len;
  logic [2:0]      exec_cyc;

  // class flags, byte length and cycle count all come from one decode
  always_comb begin
    dcd      = decode(instr.opcode);
    exec_len = instr_len(dcd);
    exec_cyc = instr_cycles(dcd);
  end

  // ---------------------------------------------------------------
  // combinational execute of the issued instruction
  // ---------------------------------------------------------------
  cdib_result_type exec_res;
  logic [7:0]      src_byte;
  logic            src_bit;
  logic [7:0]      dec_byte;
  logic [7:0]      inc_byte;
  logic [7:0]      rel_off;
  logic            take_br;
  logic [15:0]     seq_addr;

  // the divider is a plain combinational one; its result is registered at issue, so it must settle within that one cycle
  always_comb begin
    src_byte = rmw_byte(opnd);
    src_bit  = rmw_bit(opnd);
    dec_byte = 8'(src_byte - BYTE_ONE);
    inc_byte = 8'(src_byte + BYTE_ONE);
    // a three-byte form keeps its offset in the last byte
    rel_off  = (exec_len == LEN_THREE) ? instr.arg2 : instr.arg1;
    seq_addr = 16'(arch.program_counter + exec_len);
    take_br  = 1'b0;
    exec_res                 = '0;
    exec_res.acc             = arch.acc;
    exec_res.second_operand  = arch.second_operand;
    exec_res.data_pointer    = arch.data_pointer;
    exec_res.carry           = arch.carry;
    exec_res.operand         = src_byte;
    if (dcd.divide) begin
      exec_res.carry         = 1'b0;
      exec_res.carry_we      = 1'b1;
      exec_res.overflow_we   = 1'b1;
      if (arch.second_operand == BYTE_ZERO) begin
        exec_res.overflow_flag = 1'b1;
      end else begin
        exec_res.acc            = arch.acc / arch.second_operand;
        exec_res.second_operand = arch.acc % arch.second_operand;
        exec_res.acc_we         = 1'b1;
        exec_res.second_we      = 1'b1;
        exec_res.overflow_flag  = 1'b0;
      end
    end else if (dcd.dec_br_reg || dcd.dec_br_direct) begin
      exec_res.operand    = dec_byte;
      exec_res.operand_we = 1'b1;
      take_br             = (dec_byte != BYTE_ZERO);
    end else if (dcd.inc_acc) begin
      exec_res.acc    = 8'(arch.acc + BYTE_ONE);
      exec_res.acc_we = 1'b1;
    end else if (dcd.inc_short || dcd.inc_direct) begin
      exec_res.operand    = inc_byte;
      exec_res.operand_we = 1'b1;
    end else if (dcd.inc_data_ptr) begin
      exec_res.data_pointer    = 16'(arch.data_pointer + WORD_ONE);
      exec_res.data_pointer_we = 1'b1;
    end else if (dcd.br_bit_set) begin
      take_br = src_bit;
    end else if (dcd.br_bit_clr) begin
      // only a bit that was one is cleared
      exec_res.bit_clear = src_bit;
      take_br            = src_bit;
    end else if (dcd.br_bit_not) begin
      take_br = !src_bit;
    end else if (dcd.br_carry) begin
      take_br = arch.carry;
    end else if (dcd.jump_indirect) begin
      take_br = 1'b0;                                    // target is absolute
    end else begin
      // outside this unit's subset: flag it, write nothing, and step the counter past one byte
      exec_res.illegal = 1'b1;
    end
    // a branch not taken simply falls through to the next instruction
    exec_res.program_counter = take_br ? rel_target(seq_addr, rel_off) : seq_addr;
    if (dcd.jump_indirect) begin
      exec_res.program_counter = 16'(arch.data_pointer + {BYTE_ZERO, arch.acc});
    end
  end

  // ---------------------------------------------------------------
  // sequencer: hold results until the cycle count has run out
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r.fsm)
      CDIB_IDLE: begin
        // issue is ignored while busy, so only idle takes it
        if (issue) begin
          state_nxt.fsm = CDIB_EXEC;
          state_nxt.cnt = 3'(exec_cyc - CNT_ONE);
          state_nxt.res = exec_res;
        end
      end
      CDIB_EXEC: begin
        if (state_r.cnt == CNT_ZERO) begin
          state_nxt.fsm = CDIB_IDLE;
        end else begin
          state_nxt.cnt = 3'(state_r.cnt - CNT_ONE);
        end
      end
      default: begin
        state_nxt.fsm = CDIB_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // results come from flops; done marks the last cycle of execution
  assign busy   = (state_r.fsm == CDIB_EXEC);
  assign done   = busy && (state_r.cnt == CNT_ZERO);
  assign result = state_r.res;

endmodule : cdib_exec

// ==== sim/cdib_exec_assertions.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port checks on the execution unit
// ---------------------------------------------------------------
module cdib_exec_chk (
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  input wire logic                      issue,
  input wire cdib_pkg::cdib_instr_type   instr,
  input wire cdib_pkg::cdib_arch_type    arch,
  input wire cdib_pkg::cdib_operand_type opnd,
  input wire logic                      busy,
  input wire logic                      done,
  input wire cdib_pkg::cdib_result_type  result
);
  import cdib_pkg::*;
  // request accepted at this edge
  wire logic       take    = issue & ~busy;
  wire logic [7:0] opc     = instr.opcode;
  // tested bit as a read-modify-write must pick it
  wire logic       bit_src = opnd.bit_is_port ? opnd.bit_latch : opnd.bit_pin;
  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : sx
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_DIV_TIME: assert property (take && opc == OPC_DIVIDE |=>
    (busy && !done) [*3] ##1 done)
    else $error("divide not done in four cycles");
  AST_INC_ACC: assert property (take && opc == OPC_INC_ACC |=>
    done && result.acc_we && result.acc == $past(arch.acc) + BYTE_ONE)
    else $error("accumulator increment wrong");
  AST_TWO_CYC: assert property (take && (opc == OPC_INC_DATA_PTR ||
    (opc & MASK_REG_FORM) == OPC_DEC_BR_REG) |=> !done ##1 done ##1 !busy)
    else $error("two cycle timing wrong");
  AST_DIV_ZERO: assert property (take && opc == OPC_DIVIDE &&
    arch.second_operand == BYTE_ZERO |=> result.overflow_flag && result.overflow_we &&
    !result.carry && result.carry_we)
    else $error("zero divisor flags wrong");
  AST_DIV_VAL: assert property (take && opc == OPC_DIVIDE &&
    arch.second_operand != BYTE_ZERO |=>
    result.acc == $past(arch.acc) / $past(arch.second_operand) &&
    result.second_operand == $past(arch.acc) % $past(arch.second_operand) &&
    !result.overflow_flag)
    else $error("quotient or remainder wrong");
  AST_DATA_PTR: assert property (take && opc == OPC_INC_DATA_PTR |=>
    result.data_pointer_we && result.data_pointer == $past(arch.data_pointer) + WORD_ONE &&
    !result.carry_we)
    else $error("data pointer increment wrong");
  AST_JUMP: assert property (take && opc == OPC_JUMP_INDIRECT |=>
    result.program_counter == $past(arch.data_pointer) + {8'h00, $past(arch.acc)} &&
    !result.acc_we && !result.data_pointer_we)
    else $error("indirect jump target wrong");
  AST_CARRY_BR: assert property (take && opc == OPC_BR_CARRY |=>
    result.program_counter == $past(arch.program_counter) + LEN_TWO +
    ($past(arch.carry) ? sx($past(instr.arg1)) : 16'h0000))
    else $error("carry branch target wrong");
  AST_BIT_CLR: assert property (take && opc == OPC_BR_BIT_CLR |=>
    result.bit_clear == $past(bit_src))
    else $error("bit clear decision wrong");
  AST_HOLD: assert property (busy && !done |=> $stable(result))
    else $error("result moved mid instruction");
endmodule : cdib_exec_chk

bind cdib_exec cdib_exec_chk chk_u (.ref_clk, .rst_n, .issue, .instr, .arch, .opnd, .busy,
  .done, .result);

// ==== sim/cdib_mem_model.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// operand store: pin view is the inverse of the latch view, except after reset when both are zero
// ---------------------------------------------------------------
module cdib_mem_model (
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     done,
  input wire cdib_pkg::cdib_result_type result,
  output cdib_pkg::cdib_operand_type   opnd
);
  import cdib_pkg::*;
  // a wrong view choice shows as a flipped value
  task automatic load(input logic [7:0] b, input logic bt, input logic port);
    opnd <= {~b, b, port, ~bt, bt, port};
  endtask : load
  // write-back of the byte target and the tested bit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd <= '0;
    end else if (done && result.operand_we) begin
      opnd.byte_latch <= result.operand;
      opnd.byte_pin   <= ~result.operand;
    end else if (done && result.bit_clear) begin
      opnd.bit_latch <= 1'b0;
      opnd.bit_pin   <= 1'b1;
    end
  end
endmodule : cdib_mem_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`define CDIB_CHECK(got, want, msg) begin total_checks++; if ((got) !== (want)) begin \
  failures++; $display("mismatch at %0t: %s", $time, msg); end end
module tb;
  import cdib_pkg::*;
  typedef struct packed {logic [2:0] n; cdib_result_type r;} cdib_exp_type;
  logic             ref_clk, rst_n, issue, busy, done;
  cdib_instr_type   instr;
  cdib_arch_type    arch;
  cdib_operand_type opnd;
  cdib_result_type  result;
  cdib_exp_type     exp_q[$];
  cdib_exp_type     e;
  logic [2:0]       cnt;
  logic [63:0]      rnd;
  logic [31:0]      r2;
  int               failures, total_checks, cycles, j;
  cdib_exec dut_u (.ref_clk, .rst_n, .issue, .instr, .arch, .opnd, .busy, .done, .result);
  cdib_mem_model mem_u (.ref_clk, .rst_n, .done, .result, .opnd);
  // ---------------------------------------------------------------
  // reference model: unwritten fields are zeroed on both sides
  // ---------------------------------------------------------------
  function automatic cdib_result_type clean(cdib_result_type r);
    if (!r.acc_we) r.acc = '0;
    if (!r.second_we) r.second_operand = '0;
    if (!r.data_pointer_we) r.data_pointer = '0;
    if (!r.carry_we) r.carry = 1'b0;
    if (!r.overflow_we) r.overflow_flag = 1'b0;
    if (!r.operand_we) r.operand = '0;
    return r;
  endfunction : clean
  function automatic cdib_exp_type model(cdib_instr_type i, cdib_arch_type a, logic [7:0] b,
                                         logic bt);
    cdib_exp_type x;
    logic         tk;
    logic [15:0]  off;
    x = '0;
    x.n = 3'h2;
    tk = 1'b0;
    off = {{8{i.arg2[7]}}, i.arg2};
    x.r.program_counter = a.program_counter + 16'h0003;
    casez (i.opcode)
      8'h84: begin
        x.n = 3'h4;
        x.r.program_counter = a.program_counter + 16'h0001;
        {x.r.carry_we, x.r.overflow_we} = 2'h3;
        x.r.overflow_flag = (a.second_operand == 8'h00);
        if (a.second_operand != 8'h00) begin
          x.r.acc = a.acc / a.second_operand;
          x.r.second_operand = a.acc % a.second_operand;
          {x.r.acc_we, x.r.second_we} = 2'h3;
        end
      end
      8'b11011???, 8'hD5: begin
        if (i.opcode != 8'hD5) x.r.program_counter = a.program_counter + 16'h0002;
        if (i.opcode != 8'hD5) off = {{8{i.arg1[7]}}, i.arg1};
        x.r.operand = b - 8'h01;
        x.r.operand_we = 1'b1;
        tk = (x.r.operand != 8'h00);
      end
      8'h04: begin
        x.n = 3'h1;
        x.r.program_counter = a.program_counter + 16'h0001;
        x.r.acc = a.acc + 8'h01;
        x.r.acc_we = 1'b1;
      end
      8'b00001???, 8'b0000011?, 8'h05: begin
        x.n = 3'h1;
        x.r.program_counter = a.program_counter + ((i.opcode == 8'h05) ? 16'h0002 : 16'h0001);
        x.r.operand = b + 8'h01;
        x.r.operand_we = 1'b1;
      end
      8'hA3: begin
        x.r.program_counter = a.program_counter + 16'h0001;
        x.r.data_pointer = a.data_pointer + 16'h0001;
        x.r.data_pointer_we = 1'b1;
      end
      8'h20: tk = bt;
      8'h10: {tk, x.r.bit_clear} = {bt, bt};
      8'h30: tk = !bt;
      8'h40: begin
        x.r.program_counter = a.program_counter + 16'h0002;
        off = {{8{i.arg1[7]}}, i.arg1};
        tk = a.carry;
      end
      8'h73: x.r.program_counter = a.data_pointer + {8'h00, a.acc};
      default: begin
        x.n = 3'h1;
        x.r.program_counter = a.program_counter + 16'h0001;
        x.r.illegal = 1'b1;
      end
    endcase
    if (tk) x.r.program_counter = x.r.program_counter + off;
    return x;
  endfunction : model
  // ---------------------------------------------------------------
  // driver: one instruction, waits for done under a bound
  // ---------------------------------------------------------------
  task automatic run(input logic [7:0] op, a1, a2, input cdib_arch_type ar,
                     input logic [7:0] b, input logic bt, port);
    int k;
    @(posedge ref_clk);
    mem_u.load(b, bt, port);
    instr <= {op, a1, a2};
    arch  <= ar;
    issue <= 1'b1;
    exp_q.push_back(model({op, a1, a2}, ar, port ? b : ~b, port ? bt : ~bt));
    @(posedge ref_clk);
    issue <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8) begin
      @(posedge ref_clk);
      k++;
    end
    `CDIB_CHECK(done, 1'b1, "no done")
  endtask : run
  task automatic conclude();
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // monitor: oldest note against each finished instruction, plus hang guard
  always @(posedge ref_clk) begin
    if (done === 1'b1) begin
      `CDIB_CHECK(exp_q.size() > 0, 1'b1, "unexpected done")
      e = exp_q.pop_front();
      `CDIB_CHECK(cnt, e.n, "cycle count")
      `CDIB_CHECK(clean(result), e.r, "result")
    end
    if (issue && !busy) cnt = 3'h1;
    else if (busy) cnt = cnt + 3'h1;
    cycles++;
    if (cycles > 20000) begin
      failures++;
      conclude();
    end
  end
  // main sequence: boundary cases, then every opcode with random operands
  initial begin
    {failures, total_checks, cycles, cnt} = '0;
    {rst_n, issue, instr, arch} = '0;
    void'($urandom(32'h5d55));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    run(8'h84, 8'h00, 8'h00, {16'h0100, 16'h0000, 8'hFB, 8'h12, 1'b1}, 8'h00, 1'b0, 1'b0);
    run(8'h84, 8'h00, 8'h00, {16'h0100, 16'h0000, 8'h07, 8'h00, 1'b1}, 8'h00, 1'b0, 1'b0);
    run(8'hDB, 8'h80, 8'h00, {16'h0010, 16'h0000, 8'h00, 8'h00, 1'b0}, 8'h00, 1'b0, 1'b1);
    run(8'hD5, 8'h30, 8'h7F, {16'hFFF0, 16'h0000, 8'h00, 8'h00, 1'b0}, 8'h01, 1'b0, 1'b1);
    run(8'h04, 8'h00, 8'h00, {16'hFFFF, 16'h0000, 8'hFF, 8'h00, 1'b0}, 8'hFF, 1'b0, 1'b0);
    run(8'hA3, 8'h00, 8'h00, {16'h0200, 16'hFFFF, 8'h00, 8'h00, 1'b0}, 8'h00, 1'b0, 1'b0);
    run(8'h73, 8'h00, 8'h00, {16'h0300, 16'hFFF0, 8'hFF, 8'h00, 1'b1}, 8'h00, 1'b0, 1'b0);
    run(8'h40, 8'h80, 8'h00, {16'h0000, 16'h0000, 8'h00, 8'h00, 1'b1}, 8'h00, 1'b0, 1'b0);
    run(8'h10, 8'h00, 8'h80, {16'h0000, 16'h0000, 8'h00, 8'h00, 1'b0}, 8'h00, 1'b1, 1'b1);
    for (j = 0; j < 768; j++) begin
      rnd = {$urandom(), $urandom()};
      r2 = $urandom();
      run(j[7:0], r2[7:0], r2[15:8], rnd[56:0], r2[23:16], r2[24], r2[25]);
    end
    repeat (2) @(posedge ref_clk);
    `CDIB_CHECK(exp_q.size(), 0, "results left over")
    conclude();
  end
endmodule : tb
